//--- design/flash_cmd_consts.svh
// constants for the flash command/status register block
// assumes inclusion by the design module and the testbench
`ifndef FLASH_CMD_CONSTS_SVH
`define FLASH_CMD_CONSTS_SVH
`define OFS_STATUS 12'h000
`define OFS_COMMAND 12'h004
`define OFS_CONTROL 12'h008
`define OFS_CONFIG 12'h00C
`define OFS_CLKDIV 12'h010
`define BIT_BEF 7
`define BIT_CCF 6
`define BIT_PVF 5
`define BIT_AEF 4
`define BIT_BLANK 2
`define BIT_FAIL 1
`define BIT_BEIE 7
`define BIT_COMMAND_COMPLETE_IRQ_ENABLE 6
`define CMD_ERASE_VERIFY 7'h05
`define CMD_DATA_COMPRESS 7'h06
`define CMD_WORD_PROGRAM 7'h20
`define CMD_SECTOR_ERASE 7'h40
`define CMD_MASS_ERASE 7'h41
`define CMD_SECTOR_ABORT 7'h47
`define RST_CONFIG 8'h00
`define RST_CLKDIV 7'h00
`endif

//--- design/flash_cmd_pkg.sv
// types for the flash command/status register block
// assumes flash_cmd_consts.svh is on the include path
package flash_cmd_pkg;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_WORD, SEQ_CMD} seq_state_t;
  typedef struct packed {
    logic start;
    logic [6:0] code;
    logic erase_verify;
    logic data_compress;
  } launch_t;
  typedef struct packed {
    logic done;
    logic blank;
    logic prot_viol;
    logic op_err;
  } exec_result_t;
endpackage

//--- design/flash_command_status_regs.sv
// flash command, status and control registers on an apb slave
// assumes an execution stage that takes launch pulses and reports done/errors
//
// Behaviour
// RL1: buffer-empty flag bit 7 set when buffers free; write 1 clears, 0 ignored.
// RL2: write 0 to buffer-empty after word store aborts sequence, sets access error.
// RL3: write 0 to buffer-empty outside a sequence leaves access error alone.
// RL4: buffer-empty flag with its enable requests an interrupt.
// RL5: command-complete bit 6 clears with buffer-empty, sets when all commands done.
// RL6: command-complete ignores writes; with its enable requests an interrupt.
// RL7: protection-violation bit 5 set on protected target; write 1 clears.
// RL8: protection violation set blocks sequence start and launch.
// RL9: access error bit 4 on sequence fault, bad code, erase abort, stop.
// RL10: write 1 clears access error; while set no sequence start or launch.
// RL11: access error from verify or compress discards buffered command.
// RL12: after erase-verify completes, bit 2 shows blank result.
// RL13: blank bit clears on new valid launch; writes ignored.
// RL14: failure bit 1 set when verify finds not erased; write 1 clears.
// RL15: failure bit visible and writable only in special mode, else reads 0.
// RL16: command bits 6..0 read/write in sequence; bit 7 reads 0.
// RL17: accepted codes 05, 06, 20, 40, 41, 47.
// RL18: any other code written sets access error.
// RL19: control register loaded from configuration byte at reset, read-only; here reset clears it and a config_load pulse loads it.
// RL20: control bits 7..0 are general nonvolatile bits.
// RL21: sequence is word write, code write, launch, no other writes between.
// RL22: no command executes before clock divider written since reset.
// RL23: valid launch hands command to execution, buffer-empty sets when free.
`timescale 1ns/10ps
`include "flash_cmd_consts.svh"
module flash_command_status_regs (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic special_mode,
  input wire logic [7:0] config_byte,
  input wire logic config_load,
  input wire logic array_word_write,
  input wire logic stop_request,
  input wire logic exec_ready,
  input wire flash_cmd_pkg::exec_result_t exec_result,
  output flash_cmd_pkg::launch_t launch,
  output logic buffer_empty_irq,
  output logic command_complete_irq
);

  // ****************************************
  // apb decode
  // ****************************************
  logic wr_en;
  logic rd_en;
  logic hit;
  logic [7:0] wbyte;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  assign pready = 1'b1;
  assign hit = (paddr == `OFS_STATUS) | (paddr == `OFS_COMMAND) |
    (paddr == `OFS_CONTROL) | (paddr == `OFS_CONFIG) | (paddr == `OFS_CLKDIV);
  assign pslverr = psel & penable & ~hit;
  assign wbyte = pwdata[7:0];

  logic wr_status;
  logic wr_command;
  logic wr_config;
  logic wr_clkdiv;
  assign wr_status = wr_en & (paddr == `OFS_STATUS);
  assign wr_command = wr_en & (paddr == `OFS_COMMAND);
  assign wr_config = wr_en & (paddr == `OFS_CONFIG);
  assign wr_clkdiv = wr_en & (paddr == `OFS_CLKDIV);

  // ****************************************
  // state
  // ****************************************
  flash_cmd_pkg::seq_state_t seq_q;
  logic bef_q;
  logic ccf_q;
  logic pvf_q;
  logic aef_q;
  logic blank_q;
  logic fail_q;
  logic [6:0] cmd_q;
  logic [7:0] control_q;
  logic [7:0] config_q;
  logic [6:0] clkdiv_q;
  logic div_loaded_q;
  logic pend_q;
  logic [6:0] pend_cmd_q;
  logic busy_q;
  logic [6:0] act_cmd_q;
  logic stop_s1_q;
  logic stop_s2_q;

  // ****************************************
  // command decode
  // ****************************************
  logic code_ok;
  logic blocked;
  logic launch_req;
  logic abort_seq;
  logic stop_err;
  logic verify_err;
  logic take_pend;
  // rl17 code table
  always_comb begin
    case (wbyte[6:0])
      `CMD_ERASE_VERIFY, `CMD_DATA_COMPRESS, `CMD_WORD_PROGRAM,
      `CMD_SECTOR_ERASE, `CMD_MASS_ERASE, `CMD_SECTOR_ABORT: code_ok = 1'b1;
      default: code_ok = 1'b0;
    endcase
  end
  // rl8 rl10 error blocking
  assign blocked = pvf_q | aef_q;
  assign launch_req = wr_status & wbyte[`BIT_BEF] & (seq_q == flash_cmd_pkg::SEQ_CMD) & ~blocked;
  // rl2 rl3 zero-write abort
  assign abort_seq = wr_status & ~wbyte[`BIT_BEF] & (seq_q != flash_cmd_pkg::SEQ_IDLE);
  assign stop_err = stop_s2_q & ~ccf_q;
  assign verify_err = exec_result.done & exec_result.op_err &
    ((act_cmd_q == `CMD_ERASE_VERIFY) | (act_cmd_q == `CMD_DATA_COMPRESS));
  // rl22 divider gate
  assign take_pend = pend_q & (~busy_q | exec_result.done) & exec_ready & div_loaded_q &
    ~verify_err & ~blocked;

  // ****************************************
  // stop synchroniser
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_s1_q <= 1'b0;
      stop_s2_q <= 1'b0;
    end else begin
      stop_s1_q <= stop_request;
      stop_s2_q <= stop_s1_q;
    end
  end

  // ****************************************
  // sequence tracker
  // ****************************************
  // rl21 sequence steps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_q <= flash_cmd_pkg::SEQ_IDLE;
    end else begin
      case (seq_q)
        flash_cmd_pkg::SEQ_IDLE: begin
          if (array_word_write && !blocked) begin
            seq_q <= flash_cmd_pkg::SEQ_WORD;
          end
        end
        flash_cmd_pkg::SEQ_WORD: begin
          if (abort_seq || wr_status || wr_config || wr_clkdiv) begin
            seq_q <= flash_cmd_pkg::SEQ_IDLE;
          end else if (wr_command) begin
            seq_q <= code_ok ? flash_cmd_pkg::SEQ_CMD : flash_cmd_pkg::SEQ_IDLE;
          end
        end
        flash_cmd_pkg::SEQ_CMD: begin
          if (wr_status || wr_command || wr_config || wr_clkdiv || array_word_write) begin
            seq_q <= flash_cmd_pkg::SEQ_IDLE;
          end
        end
        default: seq_q <= flash_cmd_pkg::SEQ_IDLE;
      endcase
    end
  end

  // ****************************************
  // command register
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_q <= 7'h00;
    end else if (wr_command && seq_q == flash_cmd_pkg::SEQ_WORD) begin
      // rl16 seven code bits
      cmd_q <= wbyte[6:0];
    end
  end

  // ****************************************
  // buffer and execution stage
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q <= 1'b0;
      pend_cmd_q <= 7'h00;
    end else if (launch_req) begin
      // rl23 buffer the command
      pend_q <= 1'b1;
      pend_cmd_q <= cmd_q;
    end else if (take_pend || verify_err) begin
      // rl11 discard on verify error
      pend_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q <= 1'b0;
      act_cmd_q <= 7'h00;
    end else if (take_pend) begin
      busy_q <= 1'b1;
      act_cmd_q <= pend_cmd_q;
    end else if (exec_result.done) begin
      busy_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      launch <= '0;
    end else begin
      launch.start <= take_pend;
      launch.code <= pend_cmd_q;
      launch.erase_verify <= take_pend & (pend_cmd_q == `CMD_ERASE_VERIFY);
      launch.data_compress <= take_pend & (pend_cmd_q == `CMD_DATA_COMPRESS);
    end
  end

  // ****************************************
  // status flags
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bef_q <= 1'b1;
    end else if (array_word_write && !bef_q) begin
      bef_q <= 1'b1;
    end else if (launch_req) begin
      // rl1 write one clears
      bef_q <= 1'b0;
    end else if (!pend_q) begin
      // rl23 refill when free
      bef_q <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ccf_q <= 1'b1;
    end else if (launch_req) begin
      // rl5 clear with buffer-empty
      ccf_q <= 1'b0;
    end else if (!pend_q && !busy_q && !launch.start) begin
      ccf_q <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pvf_q <= 1'b0;
    end else if (exec_result.done && exec_result.prot_viol) begin
      // rl7 set beats clear
      pvf_q <= 1'b1;
    end else if (wr_status && wbyte[`BIT_PVF]) begin
      pvf_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aef_q <= 1'b0;
    end else if (abort_seq || (wr_command && !code_ok) || stop_err ||
                 (exec_result.done && exec_result.op_err)) begin
      // rl9 rl18 access error sources
      aef_q <= 1'b1;
    end else if (wr_status && wbyte[`BIT_AEF]) begin
      // rl10 write one clears
      aef_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blank_q <= 1'b0;
    end else if (exec_result.done && act_cmd_q == `CMD_ERASE_VERIFY) begin
      // rl12 verify result
      blank_q <= exec_result.blank;
    end else if (launch_req) begin
      // rl13 clear on launch
      blank_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fail_q <= 1'b0;
    end else if (exec_result.done && act_cmd_q == `CMD_ERASE_VERIFY && !exec_result.blank) begin
      // rl14 verify failure
      fail_q <= 1'b1;
    end else if (wr_status && wbyte[`BIT_FAIL] && special_mode) begin
      // rl15 special mode clear
      fail_q <= 1'b0;
    end
  end

  // ****************************************
  // config, divider, control
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_q <= `RST_CONFIG;
    end else if (wr_config) begin
      config_q <= wbyte;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clkdiv_q <= `RST_CLKDIV;
      div_loaded_q <= 1'b0;
    end else if (wr_clkdiv) begin
      clkdiv_q <= wbyte[6:0];
      div_loaded_q <= 1'b1;
    end
  end

  // rl19 rl20 reset clears, config_load pulse loads config_byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_q <= 8'h00;
    end else if (config_load) begin
      control_q <= config_byte;
    end
  end

  // ****************************************
  // interrupts requests and read mux
  // ****************************************
  // rl4 rl6 flag and enable
  assign buffer_empty_irq = bef_q & config_q[`BIT_BEIE];
  assign command_complete_irq = ccf_q & config_q[`BIT_COMMAND_COMPLETE_IRQ_ENABLE];

  logic [7:0] status_rd;
  always_comb begin
    status_rd = 8'h00;
    status_rd[`BIT_BEF] = bef_q;
    status_rd[`BIT_CCF] = ccf_q;
    status_rd[`BIT_PVF] = pvf_q;
    status_rd[`BIT_AEF] = aef_q;
    status_rd[`BIT_BLANK] = blank_q;
    // rl15 hidden in normal mode
    status_rd[`BIT_FAIL] = fail_q & special_mode;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `OFS_STATUS: prdata <= {24'h00_0000, status_rd};
        `OFS_COMMAND: prdata <= {25'h000_0000, cmd_q};
        `OFS_CONTROL: prdata <= {24'h00_0000, control_q};
        `OFS_CONFIG: prdata <= {24'h00_0000, config_q};
        `OFS_CLKDIV: prdata <= {24'h00_0000, div_loaded_q, clkdiv_q};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  // rl8 rl10
  no_launch_blocked_a: assert property (@(posedge pclk) disable iff (!presetn)
    take_pend |-> !blocked) else $error("launch while error flag set");
  // rl18
  bad_code_err_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_command && !code_ok) |=> aef_q) else $error("bad code did not set error");
  // rl3
  idle_zero_ok_a: assert property (@(posedge pclk) disable iff (!presetn)
    (seq_q == flash_cmd_pkg::SEQ_IDLE && wr_status && !wbyte[`BIT_BEF] && !aef_q &&
     !wr_command && !stop_err && !exec_result.done) |=> !aef_q)
    else $error("idle zero write set error");
  // rl5
  ccf_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    launch_req |=> (!ccf_q && !bef_q)) else $error("complete flag not cleared");
  // rl22
  div_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    launch.start |-> div_loaded_q) else $error("launch before divider load");
  // rl4
  irq_be_a: assert property (@(posedge pclk) disable iff (!presetn)
    buffer_empty_irq == (bef_q && config_q[`BIT_BEIE])) else $error("irq mismatch");
  // rl15
  fail_hidden_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && paddr == `OFS_STATUS && !special_mode)
    |=> !prdata[`BIT_FAIL]) else $error("fail visible in normal mode");
  // rl16
  cmd_top_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && paddr == `OFS_COMMAND) |=> !prdata[7])
    else $error("command top bit nonzero");
endmodule

//--- tb/flash_command_status_regs_tb.sv
// self-checking bench for the flash command/status registers
// assumes the design package, header and execution model are compiled first
`timescale 1ns/10ps
`include "flash_cmd_consts.svh"
module flash_command_status_regs_tb;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic special_mode = 1'h0;
  logic config_load = 1'h0;
  logic array_word_write = 1'h0;
  logic slow = 1'h0;
  logic blank_in = 1'h1;
  logic prot_in = 1'h0;
  logic err_in = 1'h0;
  logic stop_req = 1'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic exec_ready;
  logic buffer_empty_irq;
  logic command_complete_irq;
  flash_cmd_pkg::exec_result_t exec_result;
  flash_cmd_pkg::launch_t launch;
  logic [31:0] rd;
  logic err;
  logic [6:0] last_code = 7'h00;
  int n_launch = 0;
  int n_fail = 0;
  int checks = 0;
  int cyc = 0;
  int base;

  flash_command_status_regs u_flash_command_status_regs (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .special_mode(special_mode),
    .config_byte(8'hA5), .config_load(config_load), .array_word_write(array_word_write),
    .stop_request(stop_req), .exec_ready(exec_ready), .exec_result(exec_result),
    .launch(launch), .buffer_empty_irq(buffer_empty_irq),
    .command_complete_irq(command_complete_irq));
  flash_exec_model u_flash_exec_model (.pclk(pclk), .presetn(presetn), .launch(launch),
    .slow(slow), .blank_in(blank_in), .prot_in(prot_in), .err_in(err_in),
    .exec_ready(exec_ready),
    .exec_result(exec_result));

  // ****************
  // helpers
  // ****************
  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (launch.start === 1'h1) begin
      n_launch++;
      last_code = launch.code;
    end
    if (cyc == 30000) begin
      n_fail++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(a, 1'h0, 8'h00);
    chk(rd, exp);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      apb(`OFS_STATUS, 1'h0, 8'h00);
      n++;
    end while (rd[6] !== 1'h1 && n < 60);
  endtask
  task automatic seq(input logic [7:0] c, input logic [7:0] s);
    @(posedge pclk);
    array_word_write <= 1'h1;
    @(posedge pclk);
    array_word_write <= 1'h0;
    apb(`OFS_COMMAND, 1'h1, c);
    apb(`OFS_STATUS, 1'h1, s);
  endtask

  // ****************
  // scenarios
  // ****************
  task automatic t_reset();
    rdchk(`OFS_STATUS, 32'hC0);
    rdchk(`OFS_CONTROL, 32'hA5);
    apb(`OFS_CONTROL, 1'h1, 8'h5A);
    rdchk(`OFS_CONTROL, 32'hA5);
    rdchk(12'h0FC, 32'h0);
    chk(err, 1'h1);
  endtask
  task automatic t_divider();
    seq(8'h20, 8'h80);
    rdchk(`OFS_STATUS, 32'h00);
    repeat (20) @(posedge pclk);
    chk(n_launch, 0);
    apb(`OFS_CLKDIV, 1'h1, 8'h01);
    wait_idle();
    chk(n_launch, 1);
    chk(rd, 32'hC0);
  endtask
  task automatic t_pipe_irq();
    apb(`OFS_CONFIG, 1'h1, 8'hC0);
    @(posedge pclk);
    chk(buffer_empty_irq, 1'h1);
    chk(command_complete_irq, 1'h1);
    slow <= 1'h1;
    base = n_launch;
    seq(8'h20, 8'h80);
    seq(8'h40, 8'h80);
    while (n_launch < base + 2 && cyc < 29000) @(posedge pclk);
    rdchk(`OFS_STATUS, 32'h80);
    chk(command_complete_irq, 1'h0);
    wait_idle();
    slow <= 1'h0;
    apb(`OFS_STATUS, 1'h1, 8'h40);
    rdchk(`OFS_STATUS, 32'hC0);
    apb(`OFS_CONFIG, 1'h1, 8'h00);
    @(posedge pclk);
    chk({buffer_empty_irq, command_complete_irq}, 2'h0);
  endtask
  task automatic t_errors();
    base = n_launch;
    seq(8'h7F, 8'h80);
    repeat (10) @(posedge pclk);
    rdchk(`OFS_STATUS, 32'hD0);
    chk(n_launch, base);
    apb(`OFS_STATUS, 1'h1, 8'h10);
    rdchk(`OFS_STATUS, 32'hC0);
    seq(8'h20, 8'h00);
    rdchk(`OFS_STATUS, 32'hD0);
    apb(`OFS_STATUS, 1'h1, 8'h10);
    prot_in <= 1'h1;
    seq(8'h40, 8'h80);
    wait_idle();
    prot_in <= 1'h0;
    chk(rd, 32'hE0);
    base = n_launch;
    seq(8'h20, 8'h80);
    repeat (10) @(posedge pclk);
    chk(n_launch, base);
    apb(`OFS_STATUS, 1'h1, 8'h20);
    rdchk(`OFS_STATUS, 32'hC0);
  endtask
  task automatic t_verify();
    blank_in <= 1'h0;
    seq(8'h05, 8'h80);
    wait_idle();
    chk(rd, 32'hC0);
    special_mode <= 1'h1;
    rdchk(`OFS_STATUS, 32'hC2);
    apb(`OFS_STATUS, 1'h1, 8'h02);
    rdchk(`OFS_STATUS, 32'hC0);
    blank_in <= 1'h1;
    seq(8'h05, 8'h80);
    wait_idle();
    chk(rd, 32'hC4);
    seq(8'h20, 8'h80);
    wait_idle();
    chk(rd, 32'hC0);
  endtask
  task automatic t_codes();
    logic [7:0] codes [6] = '{8'h05, 8'h06, 8'h20, 8'h40, 8'h41, 8'h47};
    foreach (codes[i]) begin
      seq(codes[i], 8'h80);
      wait_idle();
      chk(rd & 32'h10, 32'h0);
      chk(last_code, codes[i][6:0]);
    end
    @(posedge pclk);
    array_word_write <= 1'h1;
    @(posedge pclk);
    array_word_write <= 1'h0;
    apb(`OFS_COMMAND, 1'h1, 8'hA0);
    rdchk(`OFS_COMMAND, 32'h20);
    apb(`OFS_STATUS, 1'h1, 8'h80);
    wait_idle();
    chk(last_code, 7'h20);
  endtask
  task automatic t_exec_err();
    stop_req <= 1'h1;
    repeat (4) @(posedge pclk);
    stop_req <= 1'h0;
    rdchk(`OFS_STATUS, 32'hC0);
    slow <= 1'h1;
    seq(8'h20, 8'h80);
    stop_req <= 1'h1;
    repeat (4) @(posedge pclk);
    stop_req <= 1'h0;
    wait_idle();
    chk(rd, 32'hD0);
    apb(`OFS_STATUS, 1'h1, 8'h10);
    err_in <= 1'h1;
    base = n_launch;
    seq(8'h05, 8'h80);
    seq(8'h20, 8'h80);
    wait_idle();
    chk(rd, 32'hD4);
    chk(n_launch, base + 1);
    err_in <= 1'h0;
    slow <= 1'h0;
    apb(`OFS_STATUS, 1'h1, 8'h10);
  endtask

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    config_load <= 1'h1;
    @(posedge pclk);
    config_load <= 1'h0;
    t_reset();
    t_divider();
    t_pipe_irq();
    t_errors();
    t_verify();
    t_codes();
    t_exec_err();
    stop_test();
  end
endmodule

//--- tb/flash_exec_model.sv
// behavioural execution stage facing the flash command block
// assumes launch pulses from the register block on the same clock
`timescale 1ns/10ps
module flash_exec_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire flash_cmd_pkg::launch_t launch,
  input wire logic slow,
  input wire logic blank_in,
  input wire logic prot_in,
  input wire logic err_in,
  output logic exec_ready,
  output flash_cmd_pkg::exec_result_t exec_result
);
  logic [4:0] busy_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q <= 5'h00;
      exec_result <= 4'h0;
    end else begin
      exec_result <= 4'h0;
      if (launch.start) begin
        busy_q <= slow ? 5'h14 : 5'h02;
      end else if (busy_q != 5'h00) begin
        busy_q <= busy_q - 5'h01;
        if (busy_q == 5'h01) begin
          exec_result <= {1'h1, blank_in, prot_in, err_in};
        end
      end
    end
  end
  assign exec_ready = (busy_q == 5'h00);
endmodule
